// [srsoc_pkg.sv]
// package for the sensor reset and output-state control pair
// assumes both ends run on one 200 MHz core clock
`default_nettype none
package srsoc_pkg;
    // -------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    // boot interval in microseconds (44.5 ms)
    localparam int BOOT_TIME_US = 44500;
    localparam int BOOT_CYCLES = BOOT_TIME_US * CLK_MHZ;
    // host reset hold and clock margins in clock cycles
    localparam int RST_HOLD_CYCLES = 50;
    localparam int CLK_AFTER_RST_CYCLES = 10;
    localparam int CLK_BEFORE_REL_CYCLES = 10;
    // host cycles in wait before trusting synced ready
    localparam int READY_LAT_CYCLES = 8;
    // power-on reset stretch in cycles
    localparam int POR_CYCLES = 16;
    // -------------------------------------------------------------
    // soft reset register
    // -------------------------------------------------------------
    localparam logic [15:0] SYSTEM_CONTROL_REG_ADDR = 16'h001A;
    localparam int SOFT_RST_BIT = 0;
    localparam logic [15:0] SYSTEM_CONTROL_REG_RST = 16'h0000;
    // -------------------------------------------------------------
    // frame geometry
    // -------------------------------------------------------------
    localparam int ACT_COLS = 16;
    localparam int HBLANK_COLS = 8;
    localparam int ACT_ROWS = 8;
    localparam int VBLANK_ROWS = 4;
    localparam logic [9:0] BLANK_WORD = 10'h000;
    localparam int CNT_W = 32;
endpackage : srsoc_pkg
`default_nettype wire

// [srsoc_if.sv]
// link between the sensor reset/output block and its host
// assumes the device end resolves tristate pins from the enables
`default_nettype none
interface srsoc_if;
    logic rst_bar_pin;
    logic rst_bar_oe;
    logic boot_sel_pin;
    logic boot_sel_oe;
    logic oe_bar_pin;
    logic clk_run;
    logic wr_valid;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic ready;
    logic [7:0] pix_data;
    logic [1:0] pix_lsb;
    logic pixel_out_clock;
    logic row_active_flag;
    logic frame_active_flag;
    logic par_oe;
    logic [3:0] lane_out;
    logic streaming;
    modport dev (
        input rst_bar_pin, rst_bar_oe, boot_sel_pin, boot_sel_oe, oe_bar_pin, clk_run,
        input wr_valid, wr_addr, wr_data,
        output ready, pix_data, pix_lsb, pixel_out_clock, row_active_flag,
        output frame_active_flag, par_oe, lane_out, streaming
    );
    modport host (
        output rst_bar_pin, rst_bar_oe, boot_sel_pin, boot_sel_oe, oe_bar_pin, clk_run,
        output wr_valid, wr_addr, wr_data,
        input ready, streaming
    );
endinterface : srsoc_if
`default_nettype wire

// [srsoc_host.sv]
// host end: drives reset pin, clock-run flag and serial writes
// assumes one core clock shared with the device end
`default_nettype none
module srsoc_host (
    input wire logic core_clk,
    input wire logic rst,
    srsoc_if.host lnk,
    input wire logic hard_rst_req,
    input wire logic soft_rst_req,
    input wire logic boot_sel,
    input wire logic oe_bar,
    output logic busy,
    output logic dev_ready
);
    typedef enum logic [2:0] {
        SRSOC_IDLE, SRSOC_CLK_PRE, SRSOC_HOLD, SRSOC_CLK_REL, SRSOC_SOFT_SET, SRSOC_SOFT_CLR, SRSOC_WAIT
    } srsoc_hst_t;
    srsoc_hst_t st_ff;
    logic [7:0] cnt_ff;
    logic rst_bar_ff, wr_valid_ff, ready_s1_ff, ready_s2_ff;
    logic [15:0] wr_data_ff;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // reset hold timing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= SRSOC_IDLE;
            cnt_ff <= 8'h00;
            rst_bar_ff <= 1'b1;
            wr_valid_ff <= 1'b0;
            wr_data_ff <= 16'h0000;
        end else begin
            wr_valid_ff <= 1'b0;
            cnt_ff <= cnt_ff + 8'h01;
            case (st_ff)
                SRSOC_IDLE: begin
                    cnt_ff <= 8'h00;
                    if (hard_rst_req) begin
                        rst_bar_ff <= 1'b0;
                        st_ff <= SRSOC_HOLD;
                    end else if (soft_rst_req) begin
                        st_ff <= SRSOC_SOFT_SET;
                    end
                end
                SRSOC_HOLD: begin
                    // hold low with clock running
                    if (cnt_ff == 8'(srsoc_pkg::RST_HOLD_CYCLES - 1)) begin
                        cnt_ff <= 8'h00;
                        st_ff <= SRSOC_CLK_REL;
                    end
                end
                SRSOC_CLK_REL: begin
                    if (cnt_ff == 8'(srsoc_pkg::CLK_BEFORE_REL_CYCLES - 1)) begin
                        rst_bar_ff <= 1'b1;
                        cnt_ff <= 8'h00;
                        st_ff <= SRSOC_WAIT;
                    end
                end
                SRSOC_SOFT_SET: begin
                    wr_valid_ff <= 1'b1;
                    wr_data_ff <= 16'h0001;
                    st_ff <= SRSOC_SOFT_CLR;
                end
                SRSOC_SOFT_CLR: begin
                    wr_valid_ff <= 1'b1;
                    wr_data_ff <= srsoc_pkg::SYSTEM_CONTROL_REG_RST;
                    cnt_ff <= 8'h00;
                    st_ff <= SRSOC_WAIT;
                end
                SRSOC_WAIT: begin
                    // poll ready, no commands before
                    // hold the count once it tops out, so no wrap
                    if (cnt_ff == 8'hFF) begin
                        cnt_ff <= 8'hFF;
                    end
                    // stale synced ready must drain before it counts
                    if (ready_s2_ff && cnt_ff > 8'(srsoc_pkg::READY_LAT_CYCLES)) begin
                        st_ff <= SRSOC_IDLE;
                    end
                end
                default: st_ff <= SRSOC_IDLE;
            endcase
        end
    end

    // ready synchroniser
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ready_s1_ff <= 1'b0;
            ready_s2_ff <= 1'b0;
        end else begin
            ready_s1_ff <= lnk.ready;
            ready_s2_ff <= ready_s1_ff;
        end
    end

    // status outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            dev_ready <= 1'b0;
        end else begin
            busy <= (st_ff != SRSOC_IDLE);
            dev_ready <= ready_s2_ff;
        end
    end

    assign lnk.rst_bar_pin = rst_bar_ff;
    // open-drain style: only the low level is driven, pull-up gives high
    assign lnk.rst_bar_oe = ~rst_bar_ff;
    assign lnk.boot_sel_pin = boot_sel;
    assign lnk.boot_sel_oe = ~boot_sel;
    assign lnk.oe_bar_pin = oe_bar;
    assign lnk.clk_run = 1'b1;
    assign lnk.wr_valid = wr_valid_ff;
    assign lnk.wr_addr = srsoc_pkg::SYSTEM_CONTROL_REG_ADDR;
    assign lnk.wr_data = wr_data_ff;
endmodule : srsoc_host
`default_nettype wire

// [srsoc_dev.sv]
// device end: merges resets, runs boot, sets output pin states
// assumes host pins arrive asynchronously; high-Z is resolved here from the enables
// Behaviour
// - blanking surrounds frames, data zero
// - row flag high only on pixels
// - power-on reset without external pulse
// - pin, soft and power-on resets
// - parallel outputs high-Z in reset/standby
// - serial lanes driven zero in reset/standby
// - serial writes need running clock
// - soft reset equals hard reset
// - floating reset/boot-select read high
// - low reset pin enters reset state
// - output-enable high keeps boot high-Z
// - host holds reset fifty cycles
// - clock ten cycles before release
// - boot interval before ready
// - host polls for readiness
// - host waits boot before commands; host waits only after its own resets, not after power-on
// - boot-select picks streaming or standby
// - bit zero of control register
`default_nettype none
module srsoc_dev #(
    parameter int BOOT_CYCLES = srsoc_pkg::BOOT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    srsoc_if.dev lnk,
    output logic in_reset,
    output logic booted
);
    typedef enum logic [1:0] {SRSOC_BOOT, SRSOC_STANDBY, SRSOC_STREAM} srsoc_dst_t;
    srsoc_dst_t st_ff;
    logic [4:0] por_cnt_ff;
    logic por_ff;
    logic pin_s1_ff, pin_s2_ff, sel_s1_ff, sel_s2_ff;
    logic clk_s1_ff, clk_s2_ff;
    logic soft_ff;
    logic irst_a_ff, irst_ff;
    logic int_rst;
    logic [srsoc_pkg::CNT_W-1:0] boot_cnt_ff;
    logic boot_sel_ff;
    logic [7:0] col_ff;
    logic [7:0] row_ff;
    logic pclk_ff, row_flag_ff, frame_flag_ff, par_oe_ff, ready_ff, stream_ff;
    logic [9:0] word_ff;
    logic pin_lvl, sel_lvl;

    // ---------------------------------------------------------------
    // input conditioning
    // ---------------------------------------------------------------
    // undriven pins read high
    assign pin_lvl = lnk.rst_bar_oe ? lnk.rst_bar_pin : 1'b1;
    assign sel_lvl = lnk.boot_sel_oe ? lnk.boot_sel_pin : 1'b1;

    // two-flop synchronisers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
            sel_s1_ff <= 1'b1;
            sel_s2_ff <= 1'b1;
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff <= pin_lvl;
            pin_s2_ff <= pin_s1_ff;
            sel_s1_ff <= sel_lvl;
            sel_s2_ff <= sel_s1_ff;
            clk_s1_ff <= lnk.clk_run;
            clk_s2_ff <= clk_s1_ff;
        end
    end

    // ---------------------------------------------------------------
    // reset sources
    // ---------------------------------------------------------------
    // power-on reset stretch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            por_cnt_ff <= 5'h00;
            por_ff <= 1'b1;
        end else if (por_ff) begin
            por_cnt_ff <= por_cnt_ff + 5'h01;
            if (por_cnt_ff == 5'(srsoc_pkg::POR_CYCLES - 1)) begin
                por_ff <= 1'b0;
            end
        end
    end

    // soft reset bit in control register
    // writes only taken while clock runs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            soft_ff <= 1'b0;
        end else if (lnk.wr_valid && clk_s2_ff && lnk.wr_addr == srsoc_pkg::SYSTEM_CONTROL_REG_ADDR) begin
            soft_ff <= lnk.wr_data[srsoc_pkg::SOFT_RST_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irst_a_ff <= 1'b1;
            irst_ff <= 1'b1;
        end else begin
            irst_a_ff <= por_ff | ~pin_s2_ff | soft_ff;
            irst_ff <= irst_a_ff;
        end
    end
    assign int_rst = irst_ff;

    // ---------------------------------------------------------------
    // boot and system state
    // ---------------------------------------------------------------
    // boot count, boot-select choice
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= SRSOC_BOOT;
            boot_cnt_ff <= '0;
            boot_sel_ff <= 1'b1;
        end else if (int_rst) begin
            st_ff <= SRSOC_BOOT;
            boot_cnt_ff <= '0;
            boot_sel_ff <= sel_s2_ff;
        end else begin
            case (st_ff)
                SRSOC_BOOT: begin
                    boot_cnt_ff <= boot_cnt_ff + 1'b1;
                    if (boot_cnt_ff == srsoc_pkg::CNT_W'(BOOT_CYCLES - 1)) begin
                        st_ff <= boot_sel_ff ? SRSOC_STREAM : SRSOC_STANDBY;
                    end
                end
                SRSOC_STANDBY: st_ff <= SRSOC_STANDBY;
                SRSOC_STREAM: st_ff <= SRSOC_STREAM;
                default: st_ff <= SRSOC_BOOT;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // frame timing
    // ---------------------------------------------------------------
    // column and row counters, one word per two core clocks
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pclk_ff <= 1'b0;
            col_ff <= 8'h00;
            row_ff <= 8'h00;
        end else if (int_rst || st_ff != SRSOC_STREAM) begin
            pclk_ff <= 1'b0;
            col_ff <= 8'h00;
            row_ff <= 8'h00;
        end else begin
            pclk_ff <= ~pclk_ff;
            if (pclk_ff) begin
                if (col_ff == 8'(srsoc_pkg::ACT_COLS + srsoc_pkg::HBLANK_COLS - 1)) begin
                    col_ff <= 8'h00;
                    row_ff <= (row_ff == 8'(srsoc_pkg::ACT_ROWS + srsoc_pkg::VBLANK_ROWS - 1)) ?
                        8'h00 : row_ff + 8'h01;
                end else begin
                    col_ff <= col_ff + 8'h01;
                end
            end
        end
    end

    // zero words in blanking, row flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            row_flag_ff <= 1'b0;
            frame_flag_ff <= 1'b0;
            word_ff <= srsoc_pkg::BLANK_WORD;
        end else if (int_rst || st_ff != SRSOC_STREAM) begin
            row_flag_ff <= 1'b0;
            frame_flag_ff <= 1'b0;
            word_ff <= srsoc_pkg::BLANK_WORD;
        end else begin
            frame_flag_ff <= (row_ff < 8'(srsoc_pkg::ACT_ROWS));
            row_flag_ff <= (row_ff < 8'(srsoc_pkg::ACT_ROWS)) && (col_ff < 8'(srsoc_pkg::ACT_COLS));
            word_ff <= ((row_ff < 8'(srsoc_pkg::ACT_ROWS)) && (col_ff < 8'(srsoc_pkg::ACT_COLS))) ?
                {row_ff[4:0], col_ff[4:0]} : srsoc_pkg::BLANK_WORD;
        end
    end

    // ---------------------------------------------------------------
    // output pin state
    // ---------------------------------------------------------------
    // parallel enable only when streaming
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            par_oe_ff <= 1'b0;
            ready_ff <= 1'b0;
            stream_ff <= 1'b0;
        end else begin
            par_oe_ff <= ~int_rst && st_ff == SRSOC_STREAM;
            ready_ff <= ~int_rst && st_ff != SRSOC_BOOT;
            stream_ff <= ~int_rst && st_ff == SRSOC_STREAM;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            in_reset <= 1'b1;
            booted <= 1'b0;
        end else begin
            in_reset <= int_rst;
            booted <= ~int_rst && st_ff != SRSOC_BOOT;
        end
    end

    assign lnk.pix_data = word_ff[9:2];
    assign lnk.pix_lsb = word_ff[1:0];
    assign lnk.pixel_out_clock = pclk_ff;
    assign lnk.row_active_flag = row_flag_ff;
    assign lnk.frame_active_flag = frame_flag_ff;
    assign lnk.par_oe = par_oe_ff;
    assign lnk.lane_out = 4'h0;
    assign lnk.ready = ready_ff;
    assign lnk.streaming = stream_ff;
endmodule : srsoc_dev
`default_nettype wire

// [srsoc_asserts.sv]
// checker for the reset and output-state link
// assumes one core clock and active-high async reset
`default_nettype none
module srsoc_asserts #(
    parameter int BOOT_CYCLES = srsoc_pkg::BOOT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rst_bar_pin,
    input wire logic rst_bar_oe,
    input wire logic clk_run,
    input wire logic oe_bar_pin,
    input wire logic wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic ready,
    input wire logic [7:0] pix_data,
    input wire logic [1:0] pix_lsb,
    input wire logic row_active_flag,
    input wire logic frame_active_flag,
    input wire logic par_oe,
    input wire logic [3:0] lane_out,
    input wire logic streaming
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [31:0] low_cnt_ff;
    // ---------------------------------------------
    // helper: cycles spent not ready
    // ---------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) low_cnt_ff <= 32'h0;
        else if (ready) low_cnt_ff <= 32'h0;
        else low_cnt_ff <= low_cnt_ff + 32'h1;
    end
    // ---------------------------------------------
    // sequences and properties
    // ---------------------------------------------
    sequence s_soft_set;
        wr_valid && wr_addr == srsoc_pkg::SYSTEM_CONTROL_REG_ADDR && wr_data[0] && clk_run;
    endsequence
    sequence s_ready_drop;
        ##[1:8] !ready;
    endsequence
    sequence s_pin_low;
        (rst_bar_oe && !rst_bar_pin) [*8];
    endsequence
    property p_soft_rst;
        s_soft_set |-> s_ready_drop;
    endproperty
    property p_pin_hold;
        s_pin_low |-> !ready && !par_oe;
    endproperty
    property p_por;
        $fell(rst) |-> !ready [*8];
    endproperty
    property p_boot_len;
        $rose(ready) |-> low_cnt_ff >= BOOT_CYCLES;
    endproperty
    property p_boot_hiz;
        !ready |-> !par_oe;
    endproperty
    property p_standby_hiz;
        !streaming |-> !par_oe;
    endproperty
    property p_oe_hiz;
        oe_bar_pin && !streaming |-> !par_oe;
    endproperty
    property p_lanes_zero;
        !streaming |-> lane_out == 4'h0;
    endproperty
    property p_blank_zero;
        par_oe && !row_active_flag |-> {pix_data, pix_lsb} == 10'h000;
    endproperty
    property p_row_in_frame;
        row_active_flag |-> frame_active_flag;
    endproperty
    a_soft_rst: assert property (p_soft_rst)
        else $error("soft reset did not drop ready");
    a_pin_hold: assert property (p_pin_hold)
        else $error("held reset pin left device active");
    a_por: assert property (p_por)
        else $error("ready too soon after power-on");
    a_boot_len: assert property (p_boot_len)
        else $error("boot interval too short");
    a_boot_hiz: assert property (p_boot_hiz)
        else $error("parallel pins driven before ready");
    a_standby_hiz: assert property (p_standby_hiz)
        else $error("parallel pins driven outside streaming");
    a_oe_hiz: assert property (p_oe_hiz)
        else $error("parallel pins driven while output-enable high");
    a_lanes_zero: assert property (p_lanes_zero)
        else $error("lanes not zero outside streaming");
    a_blank_zero: assert property (p_blank_zero)
        else $error("blanking data not zero");
    a_row_in_frame: assert property (p_row_in_frame)
        else $error("row flag outside frame");
endmodule : srsoc_asserts
`default_nettype wire

// [test_srsoc.sv]
// self-checking bench joining host and device ends
// assumes a shortened boot count and one core clock
`default_nettype none
module test_srsoc;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BOOT = 50;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hard_rst_req = 1'b0;
    logic soft_rst_req = 1'b0;
    logic boot_sel = 1'b1;
    logic oe_bar = 1'b0;
    logic busy;
    logic dev_ready;
    logic dev_in_reset;
    logic dev_booted;
    int errors = 0;
    int compares = 0;
    srsoc_if lnk ();
    srsoc_host u_srsoc_host (.core_clk(core_clk), .rst(rst), .lnk(lnk), .hard_rst_req(hard_rst_req),
        .soft_rst_req(soft_rst_req), .boot_sel(boot_sel), .oe_bar(oe_bar), .busy(busy), .dev_ready(dev_ready));
    srsoc_dev #(.BOOT_CYCLES(BOOT)) u_srsoc_dev (.core_clk(core_clk), .rst(rst), .lnk(lnk),
        .in_reset(dev_in_reset), .booted(dev_booted));
    srsoc_asserts #(.BOOT_CYCLES(BOOT)) u_srsoc_asserts (.core_clk(core_clk), .rst(rst),
        .rst_bar_pin(lnk.rst_bar_pin), .rst_bar_oe(lnk.rst_bar_oe), .clk_run(lnk.clk_run),
        .oe_bar_pin(lnk.oe_bar_pin),
        .wr_valid(lnk.wr_valid), .wr_addr(lnk.wr_addr), .wr_data(lnk.wr_data), .ready(lnk.ready),
        .pix_data(lnk.pix_data), .pix_lsb(lnk.pix_lsb), .row_active_flag(lnk.row_active_flag),
        .frame_active_flag(lnk.frame_active_flag), .par_oe(lnk.par_oe), .lane_out(lnk.lane_out),
        .streaming(lnk.streaming));
    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    function automatic int exp_row_cycles();
        return 2 * srsoc_pkg::ACT_COLS * srsoc_pkg::ACT_ROWS;
    endfunction : exp_row_cycles
    task automatic end_sim();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch t=%0t %s", $time, msg);
        end
    endtask : check
    task automatic wait_ready(output int n);
        n = 0;
        while (dev_ready !== 1'b1) begin
            @(posedge core_clk);
            n++;
            if (n > 2000) begin
                check(1'b0, "ready wait ran out");
                end_sim();
            end
        end
    endtask : wait_ready
    // request one reset and watch the pin and ready
    task automatic do_reset(input logic hard);
        int low;
        logic dropped;
        logic entered;
        logic was_busy;
        logic early;
        low = 0;
        dropped = 1'b0;
        entered = 1'b0;
        was_busy = 1'b0;
        early = 1'b0;
        check(busy === 1'b0, "host busy before request");
        if (hard) hard_rst_req <= 1'b1;
        else soft_rst_req <= 1'b1;
        @(posedge core_clk);
        hard_rst_req <= 1'b0;
        soft_rst_req <= 1'b0;
        repeat (80) begin
            @(posedge core_clk);
            if (lnk.rst_bar_oe === 1'b1 && lnk.rst_bar_pin === 1'b0) low++;
            if (lnk.ready === 1'b0) dropped = 1'b1;
            if (dev_in_reset === 1'b1) entered = 1'b1;
            if (was_busy && busy === 1'b0 && lnk.ready !== 1'b1) early = 1'b1;
            if (busy === 1'b1) was_busy = 1'b1;
        end
        check(dropped, "reset did not drop ready");
        check(entered, "internal reset not entered");
        check(was_busy, "host never waited for ready");
        check(!early, "host left wait before ready");
        check(!hard || low >= srsoc_pkg::RST_HOLD_CYCLES, "pin low too short");
    endtask : do_reset
    // state after boot, and one frame when streaming
    task automatic check_state(input logic bs);
        int rows;
        int n;
        rows = 0;
        repeat (4) @(posedge core_clk);
        check(lnk.streaming === bs, "boot-select state");
        check(dev_booted === 1'b1 && dev_in_reset === 1'b0, "device not booted");
        check(bs || lnk.par_oe === 1'b0, "standby pins driven");
        check(bs || lnk.lane_out === 4'h0, "standby lanes not zero");
        if (bs) begin
            for (int ph = 0; ph < 3; ph++) begin
                n = 0;
                while (lnk.frame_active_flag === (ph != 1) && n < 2000) begin
                    if (ph == 2 && lnk.row_active_flag === 1'b1) rows++;
                    @(posedge core_clk);
                    n++;
                end
                if (n >= 2000) begin
                    check(1'b0, "frame wait ran out");
                    end_sim();
                end
            end
            check(rows == exp_row_cycles(), "row active cycles per frame");
        end
    endtask : check_state
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        int n;
        logic bs;
        void'($urandom(32'hC48B));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wait_ready(n);
        check(n >= BOOT, "power-on boot too short");
        check_state(1'b1);
        // standby hard reset, then streaming soft reset, then four random ones
        for (int i = 0; i < 6; i++) begin
            bs = (i < 2) ? i[0] : 1'($urandom());
            boot_sel <= bs;
            oe_bar <= 1'($urandom());
            @(posedge core_clk);
            do_reset((i < 2) ? !i[0] : 1'($urandom()));
            wait_ready(n);
            check_state(bs);
        end
        end_sim();
    end
endmodule : test_srsoc
`default_nettype wire
